// ===== logic/iosmc_top.sv
// Notes on behaviour
// RL1: each machine has a free-running fractional divider giving execution enable pulses
// RL2: divider restart mask zeroes both phase accumulators of selected dividers together
// RL3: equal divisors restarted together give identical pulse trains afterwards
// RL4: lockstepped machines waiting one flag all see and clear it same cycle
// RL5: divider restart is accepted any time, even while machines run
// RL6: disabling a machine never stops its divider
// RL7: sync enable sets enable and restarts divider in one cycle
// RL8: machine restart clears shift, counters, divider, pin flags, delay, forced op, wait; here it only pulses sm_restart_o and leaves the divider running
// RL9: four machines 0..3; mask bit n selects machine n
// RL10: eight internal flags 0..7 readable by host
// RL11: host clears any one flag by number, others untouched
// RL12: two interrupt outputs each with own enable per source
// RL13: source-enable update sets or clears only masked sources on chosen output
// RL14: each machine has separate inbound and outbound DMA pacing requests
// RL15: inputs always readable; outputs reach pin only when mux selects instance
// RL16: two instances, each reports fixed instance number 0 or 1
// RL17: divisor is 16-bit integer plus 8-bit fraction
// RL18: sources are flags 0..3, each tx-not-full, each rx-not-empty
// RL19: enable only gates execution; re-enable resumes from held state
// RL20: each interrupt output is high while any enabled active source exists
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "iosmc_consts.svh"
module iosmc_top
    import iosmc_pkg::*;
#(
    parameter logic INSTANCE_NUM = 1'b0,
    parameter int   NUM_SM       = 4,
    parameter int   NUM_PINS     = 8
)
(
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [3:0]          tx_not_full_i,
    input  wire logic [3:0]          rx_not_empty_i,
    input  wire logic [3:0]          wait_flag_clr_i,
    input  wire logic [3:0]          wait_flag_num_i [4],
    input  wire logic [NUM_PINS-1:0] pin_in_i,
    input  wire logic [NUM_PINS-1:0] sm_out_i,
    input  wire logic [NUM_PINS-1:0] sm_oe_i,
    output logic [NUM_PINS-1:0]      pin_in_o,
    output logic [NUM_PINS-1:0]      pin_out_o,
    output logic [NUM_PINS-1:0]      pin_oe_o,
    output logic [3:0]               sm_enable_o,
    output logic [3:0]               exec_tick_o,
    output logic [3:0]               sm_restart_o,
    output logic [3:0]               dreq_tx_o,
    output logic [3:0]               dreq_rx_o,
    output logic [1:0]               irq_o,
    output logic                     instance_o
);
    // the register map only has room for four machines and 32 pin selects
    if (NUM_SM != 4)
    begin : g_bad_sm
        $error("exactly four machines supported");
    end
    if (NUM_PINS < 1 || NUM_PINS > 32)
    begin : g_bad_pins
        $error("pin count 1..32");
    end

    logic [3:0]          en_ff, nxt_en;
    logic [3:0]          divrst_ff, nxt_divrst;
    logic [3:0]          smrst_ff, nxt_smrst;
    logic [7:0]          flag_ff, nxt_flag;
    logic [11:0]         inte_ff [2];
    logic [11:0]         nxt_inte [2];
    logic [23:0]         div_ff [4];
    logic [23:0]         nxt_div [4];
    logic [NUM_PINS-1:0] gsel_ff, nxt_gsel;
    logic [NUM_PINS-1:0] pin_s1_ff, pin_s2_ff;
    logic [NUM_PINS-1:0] out_ff, oe_ff;
    logic                ack_ff, nxt_ack;
    logic [31:0]         rdat_ff, nxt_rdat;
    logic [11:0]         raw_src;
    logic [3:0]          tick;
    logic                wr_go;
    iosmc_op_type        op;

    // expand 8-bit-lane write under byte enables
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction : merge_bytes

    // one divider per machine, restart taken straight from the command pulse
    for (genvar g = 0; g < 4; g++)
    begin : g_div
        iosmc_clkdiv u_div
        (
            .ref_clk_i  (ref_clk_i),
            .rst_i      (rst_i),
            .div_int_i  (div_ff[g][23:8]), // RL17
            .div_frac_i (div_ff[g][7:0]),
            .restart_i  (divrst_ff[g]), // RL2
            .tick_o     (tick[g])
        );
    end

    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
    assign op    = iosmc_op_type'(wb_dat_i[`IOSMC_CMD_OP_LSB +: 3]);

    // interrupt sources in documented order
    assign raw_src = {rx_not_empty_i, tx_not_full_i, flag_ff[3:0]}; // RL18

    // register writes, command decoding and flag updates
    always_comb
    begin
        nxt_en     = en_ff;
        nxt_divrst = 4'h0;
        nxt_smrst  = 4'h0;
        nxt_flag   = flag_ff;
        nxt_inte   = inte_ff;
        nxt_div    = div_ff;
        nxt_gsel   = gsel_ff;
        // machines waiting in lockstep clear the flag together
        for (int s = 0; s < 4; s++)
        begin
            if (wait_flag_clr_i[s] && tick[s] && en_ff[s])
                nxt_flag[wait_flag_num_i[s][2:0]] = 1'b0; // RL4
        end
        if (wr_go)
        begin
            unique case (wb_adr_i)
                `IOSMC_CTRL_OFS: if (wb_sel_i[0]) nxt_en = wb_dat_i[3:0]; // RL19
                `IOSMC_CMD_OFS:
                begin
                    unique case (op)
                        IOSMC_OP_NONE:    ;
                        IOSMC_OP_DIV_RST: nxt_divrst = wb_dat_i[3:0]; // RL5
                        IOSMC_OP_SM_RST:  nxt_smrst = wb_dat_i[3:0]; // RL8
                        IOSMC_OP_EN_SET:  nxt_en = en_ff | wb_dat_i[3:0]; // RL9
                        IOSMC_OP_EN_CLR:  nxt_en = en_ff & ~wb_dat_i[3:0]; // RL6
                        IOSMC_OP_EN_SYNC:
                        begin
                            nxt_en     = en_ff | wb_dat_i[3:0]; // RL7
                            nxt_divrst = wb_dat_i[3:0];
                        end
                        IOSMC_OP_SRC_SET:
                            nxt_inte[wb_dat_i[31]] = inte_ff[wb_dat_i[31]]
                                                   | wb_dat_i[19:8]; // RL13
                        IOSMC_OP_SRC_CLR:
                            nxt_inte[wb_dat_i[31]] = inte_ff[wb_dat_i[31]]
                                                   & ~wb_dat_i[19:8]; // RL13
                    endcase
                end
                `IOSMC_FLAGCLR_OFS: nxt_flag[wb_dat_i[2:0]] = 1'b0; // RL11
                `IOSMC_INTE0_OFS: nxt_inte[0] = 12'(merge_bytes({20'h0, inte_ff[0]},
                                                 wb_dat_i, wb_sel_i)); // RL12
                `IOSMC_INTE1_OFS: nxt_inte[1] = 12'(merge_bytes({20'h0, inte_ff[1]},
                                                 wb_dat_i, wb_sel_i)); // RL12
                `IOSMC_DIV0_OFS, 8'h2c, 8'h30, 8'h34:
                    nxt_div[wb_adr_i[3:2] - 2'b10] = 24'(merge_bytes({8'h0,
                        div_ff[wb_adr_i[3:2] - 2'b10]}, wb_dat_i, wb_sel_i));
                `IOSMC_GPIOSEL_OFS: nxt_gsel = wb_dat_i[NUM_PINS-1:0];
                default: ;
            endcase
        end
        // flag set by software for test and machine signalling; set wins
        if (wr_go && wb_adr_i == `IOSMC_SETFLAG_OFS)
            nxt_flag = nxt_flag | wb_dat_i[7:0];
    end

    // bus answer: one wait state, ack drops the cycle after
    always_comb
    begin
        nxt_ack  = wb_cyc_i && wb_stb_i && !ack_ff;
        nxt_rdat = 32'h0000_0000;
        unique case (wb_adr_i)
            `IOSMC_CTRL_OFS:   nxt_rdat = {28'h0, en_ff};
            `IOSMC_FLAG_OFS:   nxt_rdat = {24'h0, flag_ff}; // RL10
            `IOSMC_INTE0_OFS:  nxt_rdat = {20'h0, inte_ff[0]};
            `IOSMC_INTE1_OFS:  nxt_rdat = {20'h0, inte_ff[1]};
            `IOSMC_INTR_OFS:   nxt_rdat = {20'h0, raw_src};
            `IOSMC_INTS0_OFS:  nxt_rdat = {20'h0, raw_src & inte_ff[0]};
            `IOSMC_INTS1_OFS:  nxt_rdat = {20'h0, raw_src & inte_ff[1]};
            `IOSMC_INFO_OFS:   nxt_rdat = {31'h0, INSTANCE_NUM}; // RL16
            `IOSMC_DIV0_OFS:   nxt_rdat = {8'h0, div_ff[0]};
            8'h2c:             nxt_rdat = {8'h0, div_ff[1]};
            8'h30:             nxt_rdat = {8'h0, div_ff[2]};
            8'h34:             nxt_rdat = {8'h0, div_ff[3]};
            `IOSMC_GPIOSEL_OFS: nxt_rdat = 32'(gsel_ff);
            default:           nxt_rdat = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            en_ff     <= 4'h0;
            divrst_ff <= 4'h0;
            smrst_ff  <= 4'h0;
            flag_ff   <= 8'h00;
            inte_ff   <= '{12'h000, 12'h000};
            div_ff    <= '{`IOSMC_DIV_RST, `IOSMC_DIV_RST, `IOSMC_DIV_RST, `IOSMC_DIV_RST};
            gsel_ff   <= '0;
            ack_ff    <= 1'b0;
            rdat_ff   <= 32'h0000_0000;
        end
        else
        begin
            en_ff     <= nxt_en;
            divrst_ff <= nxt_divrst;
            smrst_ff  <= nxt_smrst;
            flag_ff   <= nxt_flag;
            inte_ff   <= nxt_inte;
            div_ff    <= nxt_div;
            gsel_ff   <= nxt_gsel;
            ack_ff    <= nxt_ack;
            rdat_ff   <= nxt_rdat;
        end
    end

    // pin path: inputs synchronised regardless of select, outputs gated
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            out_ff    <= '0;
            oe_ff     <= '0;
        end
        else
        begin
            pin_s1_ff <= pin_in_i;
            pin_s2_ff <= pin_s1_ff; // RL15
            out_ff    <= sm_out_i & gsel_ff; // RL15
            oe_ff     <= sm_oe_i & gsel_ff;
        end
    end

    assign pin_in_o     = pin_s2_ff;
    assign pin_out_o    = out_ff;
    assign pin_oe_o     = oe_ff;
    assign wb_ack_o     = ack_ff;
    assign wb_dat_o     = rdat_ff;
    // ticks run free; enable only gates, so peers stay aligned
    assign exec_tick_o  = tick; // RL3
    assign sm_enable_o  = en_ff;
    assign sm_restart_o = smrst_ff; // RL8
    assign dreq_tx_o    = tx_not_full_i; // RL14
    assign dreq_rx_o    = rx_not_empty_i; // RL14
    assign irq_o[0]     = |(raw_src & inte_ff[0]); // RL20
    assign irq_o[1]     = |(raw_src & inte_ff[1]); // RL20
    assign instance_o   = INSTANCE_NUM; // RL16

    // command and bus checks; one request at a time, so ack cannot double
    a_div_restart_sync: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL7
        (wr_go && wb_adr_i == `IOSMC_CMD_OFS && op == IOSMC_OP_EN_SYNC)
        |=> (divrst_ff == $past(wb_dat_i[3:0]) && (en_ff & divrst_ff) == divrst_ff))
        else $error("sync enable missed");
    a_flag_clear_one: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL11
        (wr_go && wb_adr_i == `IOSMC_FLAGCLR_OFS && wait_flag_clr_i == 4'h0)
        |=> flag_ff[$past(wb_dat_i[2:0])] == 1'b0)
        else $error("flag not cleared");
    a_bus_ack_once: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !ack_ff) |=> ack_ff ##1 !ack_ff)
        else $error("ack timing wrong");
    a_irq_zero_mask: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL20
        (inte_ff[0] == 12'h000) |-> !irq_o[0])
        else $error("irq0 without enable");
    a_en_clr_keeps: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL6
        (wr_go && wb_adr_i == `IOSMC_CMD_OFS && op == IOSMC_OP_EN_CLR)
        |=> divrst_ff == 4'h0)
        else $error("disable touched divider");
    a_sm_restart_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL8
        (wr_go && wb_adr_i == `IOSMC_CMD_OFS && op == IOSMC_OP_SM_RST)
        |=> (sm_restart_o == $past(wb_dat_i[3:0])) ##1 (sm_restart_o == 4'h0))
        else $error("machine restart pulse wrong");
    a_src_other_out: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL12
        (wr_go && wb_adr_i == `IOSMC_CMD_OFS
            && (op == IOSMC_OP_SRC_SET || op == IOSMC_OP_SRC_CLR))
        |=> inte_ff[~$past(wb_dat_i[31])] == $past(inte_ff[~wb_dat_i[31]]))
        else $error("other irq output touched");
    a_pin_oe_gated: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL15
        1'b1 |=> (pin_oe_o & ~$past(gsel_ff)) == {NUM_PINS{1'b0}})
        else $error("pin driven without select");
    // a waited flag must drop on the tick that completes the wait
    for (genvar g = 0; g < 4; g++)
    begin : g_wait_chk
        a_wait_flag_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL4
            (wait_flag_clr_i[g] && tick[g] && en_ff[g]
                && !(wr_go && wb_adr_i == `IOSMC_SETFLAG_OFS))
            |=> !flag_ff[$past(wait_flag_num_i[g][2:0])])
            else $error("waited flag not cleared");
    end
endmodule : iosmc_top
`default_nettype wire

// ===== logic/iosmc_consts.svh
`ifndef IOSMC_CONSTS_SVH
`define IOSMC_CONSTS_SVH
// register byte offsets
`define IOSMC_CTRL_OFS     8'h00
`define IOSMC_CMD_OFS      8'h04
`define IOSMC_FLAG_OFS     8'h08
`define IOSMC_FLAGCLR_OFS  8'h0c
`define IOSMC_INTE0_OFS    8'h10
`define IOSMC_INTE1_OFS    8'h14
`define IOSMC_INTR_OFS     8'h18
`define IOSMC_INTS0_OFS    8'h1c
`define IOSMC_INTS1_OFS    8'h20
`define IOSMC_INFO_OFS     8'h24
`define IOSMC_DIV0_OFS     8'h28
`define IOSMC_SETFLAG_OFS  8'h38
`define IOSMC_GPIOSEL_OFS  8'h3c
// command register fields
`define IOSMC_CMD_OP_LSB   4
`define IOSMC_CMD_MASK_LSB 0
// interrupt source layout
`define IOSMC_SRC_FLAG_LSB 0
`define IOSMC_SRC_TXNF_LSB 4
`define IOSMC_SRC_RXNE_LSB 8
// reset values
`define IOSMC_DIV_RST      24'h000100
`endif

// ===== logic/iosmc_pkg.sv
package iosmc_pkg;
    typedef enum logic [2:0]
    {
        IOSMC_OP_NONE      = 3'b000,
        IOSMC_OP_DIV_RST   = 3'b001,
        IOSMC_OP_SM_RST    = 3'b010,
        IOSMC_OP_EN_SET    = 3'b011,
        IOSMC_OP_EN_CLR    = 3'b100,
        IOSMC_OP_EN_SYNC   = 3'b101,
        IOSMC_OP_SRC_SET   = 3'b110,
        IOSMC_OP_SRC_CLR   = 3'b111
    } iosmc_op_type;
endpackage : iosmc_pkg

// ===== logic/iosmc_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
// fractional divider: 16.8 phase accumulator, pulse on integer wrap
module iosmc_clkdiv
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] div_int_i,
    input  wire logic [7:0]  div_frac_i,
    input  wire logic        restart_i,
    output logic             tick_o
);
    logic [15:0] int_ff;
    logic [7:0]  frac_ff;
    logic [15:0] nxt_int;
    logic [7:0]  nxt_frac;
    logic        nxt_tick;
    logic        tick_ff;
    logic [8:0]  fsum;
    logic [15:0] limit;

    // divisor 0 is treated as 65536 by letting the count wrap
    always_comb
    begin
        fsum     = {1'b0, frac_ff} + {1'b0, div_frac_i};
        limit    = div_int_i - 16'h0001 + {15'h0000, fsum[8]};
        nxt_int  = int_ff + 16'h0001;
        nxt_frac = frac_ff;
        nxt_tick = 1'b0;
        if (restart_i)
        begin
            nxt_int  = 16'h0000; // RL2
            nxt_frac = 8'h00;
        end
        else if (int_ff >= limit && div_int_i != 16'h0000 || int_ff == 16'hffff)
        begin
            nxt_int  = 16'h0000; // RL1
            nxt_frac = fsum[7:0];
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            int_ff  <= 16'h0000;
            frac_ff <= 8'h00;
            tick_ff <= 1'b0;
        end
        else
        begin
            int_ff  <= nxt_int;
            frac_ff <= nxt_frac;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;

    // a restart must leave both accumulators at phase zero
    a_restart_phase: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL2
        restart_i |=> (int_ff == 16'h0000 && frac_ff == 8'h00 && !tick_ff))
        else $error("divider phase not cleared");
endmodule : iosmc_clkdiv
`default_nettype wire

// ===== bench/iosmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host bus master plus the queue levels that pace the dma side
module iosmc_host_model
(
    input  wire logic        ref_clk_i,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic [7:0]       wb_adr_o,
    output logic [3:0]       wb_sel_o,
    output logic [31:0]      wb_dat_o,
    output logic [3:0]       tx_nf_o,
    output logic [3:0]       rx_ne_o
);
    logic [31:0] rd_q;
    // idle bus at time zero
    initial
    begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
        tx_nf_o  = 4'h0;
        rx_ne_o  = 4'h0;
    end
    // one classic cycle; held until ack is sampled, so no early release
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= w;
        wb_adr_o <= a;
        wb_sel_o <= 4'hf;
        wb_dat_o <= d;
        // no local limit: a hung slave is caught by the bench watchdog
        do
        begin
            @(posedge ref_clk_i);
        end
        while (wb_ack_i !== 1'b1);
        rd_q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o  <= 1'b0;
    endtask : xfer
    // queue levels change only after an edge
    task automatic set_q(input logic [3:0] t, input logic [3:0] r);
        @(posedge ref_clk_i);
        tx_nf_o <= t;
        rx_ne_o <= r;
    endtask : set_q
endmodule : iosmc_host_model
`default_nettype wire

// ===== bench/test_io_state_machine_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "iosmc_consts.svh"
module test_io_state_machine_control
    import iosmc_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        cyc, stb, we, ack, inst;
    logic [7:0]  adr, pin_q, pout, poe;
    logic [3:0]  sel, txnf, rxne, ena, tick, srst, dtx, drx;
    logic [3:0]  wclr;
    logic [3:0]  wnum [4];
    logic [31:0] wdat, rdat;
    logic [7:0]  pin_in = 8'h00;
    logic [7:0]  smo    = 8'h00;
    logic [7:0]  smoe   = 8'h00;
    logic [1:0]  irq;
    logic [3:0]  rs_seen;
    int          rs_cnt, fails = 0, cmp_count = 0;
    always #12.5 ref_clk = ~ref_clk;
    iosmc_top #(.INSTANCE_NUM(1'b1)) dut_u
    (
        .ref_clk_i(ref_clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .tx_not_full_i(txnf),
        .rx_not_empty_i(rxne), .wait_flag_clr_i(wclr), .wait_flag_num_i(wnum),
        .pin_in_i(pin_in), .sm_out_i(smo), .sm_oe_i(smoe), .pin_in_o(pin_q),
        .pin_out_o(pout), .pin_oe_o(poe), .sm_enable_o(ena), .exec_tick_o(tick),
        .sm_restart_o(srst), .dreq_tx_o(dtx), .dreq_rx_o(drx), .irq_o(irq),
        .instance_o(inst)
    );
    iosmc_host_model host_u
    (
        .ref_clk_i(ref_clk), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
        .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
        .wb_dat_o(wdat), .tx_nf_o(txnf), .rx_ne_o(rxne)
    );
    // restart pulses are counted all the time, they may beat the ack
    always @(posedge ref_clk)
    begin
        if (srst !== 4'h0)
        begin
            rs_cnt++;
            rs_seen = srst;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        host_u.xfer(1'b0, a, 32'h0);
        check(host_u.rd_q, e);
    endtask : rdc
    function automatic logic [31:0] cmd(iosmc_op_type op, logic [3:0] m, logic [11:0] s,
                                        logic q);
        return {q, 11'h0, s, 1'b0, op, m};
    endfunction : cmd
    // ticks of machine a over n cycles, and cycles where machine b differs
    task automatic lock(input int a, input int b, input int n, input int e);
        int c;
        int m;
        c = 0;
        m = 0;
        repeat (n)
        begin
            @(posedge ref_clk);
            c += tick[a];
            m += (tick[a] !== tick[b]);
        end
        check(c, e);
        check(m, 0);
    endtask : lock
    task automatic t_ident;
        rdc(`IOSMC_INFO_OFS, 32'h1);
        check({31'h0, inst}, 32'h1);
        wr(8'hf0, 32'hffffffff);
        rdc(8'hf0, 32'h0);
        $display("ident done");
    endtask : t_ident
    task automatic t_flags;
        wr(`IOSMC_SETFLAG_OFS, 32'ha5);
        rdc(`IOSMC_FLAG_OFS, 32'ha5);
        rdc(`IOSMC_INTR_OFS, 32'h5);
        wr(`IOSMC_FLAGCLR_OFS, 32'h5);
        rdc(`IOSMC_FLAG_OFS, 32'h85);
        for (int i = 0; i < 8; i++)
            wr(`IOSMC_FLAGCLR_OFS, i);
        rdc(`IOSMC_FLAG_OFS, 32'h0);
        $display("flags done");
    endtask : t_flags
    task automatic t_irq;
        wr(`IOSMC_SETFLAG_OFS, 32'h02);
        wr(`IOSMC_CMD_OFS, cmd(IOSMC_OP_SRC_SET, 4'h0, 12'h00f, 1'b0));
        rdc(`IOSMC_INTE0_OFS, 32'h00f);
        rdc(`IOSMC_INTE1_OFS, 32'h0);
        check({30'h0, irq}, 32'h1);
        wr(`IOSMC_CMD_OFS, cmd(IOSMC_OP_SRC_CLR, 4'h0, 12'h002, 1'b0));
        rdc(`IOSMC_INTE0_OFS, 32'h00d);
        check({30'h0, irq}, 32'h0);
        host_u.set_q(4'h4, 4'h8);
        wr(`IOSMC_CMD_OFS, cmd(IOSMC_OP_SRC_SET, 4'h0, 12'h800, 1'b1));
        rdc(`IOSMC_INTR_OFS, 32'h842);
        rdc(`IOSMC_INTS1_OFS, 32'h800);
        rdc(`IOSMC_INTS0_OFS, 32'h0);
        check({30'h0, irq}, 32'h2);
        check({24'h0, drx, dtx}, 32'h84);
        host_u.set_q(4'h0, 4'h0);
        wr(`IOSMC_FLAGCLR_OFS, 32'h1);
        $display("irq done");
    endtask : t_irq
    task automatic t_gpio;
        @(posedge ref_clk);
        smo    <= 8'hff;
        smoe   <= 8'hff;
        pin_in <= 8'h5a;
        wr(`IOSMC_GPIOSEL_OFS, 32'h0f);
        repeat (3) @(posedge ref_clk);
        check({pin_q, poe, pout}, 32'h5a0f0f);
        $display("gpio done");
    endtask : t_gpio
    task automatic t_div;
        wr(`IOSMC_CTRL_OFS, 32'hf);
        wr(`IOSMC_DIV0_OFS, 32'h400);
        wr(`IOSMC_DIV0_OFS + 8'h08, 32'h400);
        wr(`IOSMC_CMD_OFS, cmd(IOSMC_OP_DIV_RST, 4'h5, 12'h0, 1'b0));
        repeat (2) @(posedge ref_clk);
        lock(0, 2, 12, 3);
        wr(`IOSMC_CMD_OFS, cmd(IOSMC_OP_EN_CLR, 4'h4, 12'h0, 1'b0));
        rdc(`IOSMC_CTRL_OFS, 32'hb);
        repeat (7) @(posedge ref_clk);
        wr(`IOSMC_CMD_OFS, cmd(IOSMC_OP_EN_SET, 4'h4, 12'h0, 1'b0));
        lock(0, 2, 12, 3);
        wr(`IOSMC_DIV0_OFS + 8'h04, 32'h280);
        wr(`IOSMC_DIV0_OFS + 8'h0c, 32'h280);
        wr(`IOSMC_CMD_OFS, cmd(IOSMC_OP_EN_CLR, 4'ha, 12'h0, 1'b0));
        wr(`IOSMC_CMD_OFS, cmd(IOSMC_OP_EN_SYNC, 4'ha, 12'h0, 1'b0));
        check(ena, 4'hf);
        repeat (2) @(posedge ref_clk);
        lock(1, 3, 20, 8);
        $display("divider done");
    endtask : t_div
    task automatic t_wait;
        wr(`IOSMC_SETFLAG_OFS, 32'h0c);
        @(posedge ref_clk);
        wnum <= '{4'h3, 4'h3, 4'h3, 4'h3};
        wclr <= 4'ha;
        repeat (8) @(posedge ref_clk);
        wclr <= 4'h0;
        rdc(`IOSMC_FLAG_OFS, 32'h04);
        $display("wait done");
    endtask : t_wait
    task automatic t_rst;
        int base;
        base = rs_cnt;
        wr(`IOSMC_CMD_OFS, cmd(IOSMC_OP_SM_RST, 4'h6, 12'h0, 1'b0));
        repeat (4) @(posedge ref_clk);
        check(rs_cnt - base, 1);
        check(rs_seen, 4'h6);
        $display("restart done");
    endtask : t_rst
    initial
    begin
        wclr = 4'h0;
        wnum = '{default: 4'h0};
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_ident;
        t_flags;
        t_irq;
        t_gpio;
        t_div;
        t_wait;
        t_rst;
        results;
    end
    // the whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        results;
    end
endmodule : test_io_state_machine_control
`default_nettype wire
